// file: ptm_pkg.sv
/*
  constants for the periodic task monitor timer: register map, field layout,
  reset values, channel values and sequencer state codes.
  assumes a 32-bit apb register bus with one aligned word per register.
*/
`default_nettype none

package ptm_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH = 3;
  localparam logic [11:0] CH_BASE = 12'h000;
  localparam logic [11:0] CH_STRIDE = 12'h00C;
  localparam logic [11:0] EN_OFS = 12'h000;
  localparam logic [11:0] CNT_OFS = 12'h004;
  localparam logic [11:0] CMP_OFS = 12'h008;
  localparam logic [11:0] IRQ_FLAG_ADDR = 12'h024;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h028;
  localparam logic [11:0] ACT_COUNT_ADDR = 12'h02C;

  // ----------------------------------------------------------------
  // field layout and values
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned FLAG_W = 8;
  localparam int unsigned SWITCH_FLAG_BIT = 0;
  localparam int unsigned CH1_FLAG_BIT = 1;
  localparam int unsigned CH2_FLAG_BIT = 2;
  localparam int unsigned CH3_FLAG_BIT = 4;
  localparam logic [15:0] CHANNEL_ON_VALUE = 16'h0001;
  localparam logic [15:0] CHANNEL_OFF_VALUE = 16'h0000;
  localparam logic [15:0] COUNTER_CLEAR_VALUE = 16'h0000;
  localparam logic [15:0] COUNTER_MAX = 16'hFFFF;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PTM_IDLE  = 3'b001,
    PTM_INC   = 3'b010,
    PTM_CHECK = 3'b100
  } ptm_seq_t;

endpackage

`default_nettype wire

// file: ptm_timer.sv
/*
  periodic task monitor timer: three supervisory channels advanced by a
  falling-edge trigger pin, with an apb register slave and sticky irq flags.
  assumes the trigger pin pulses low once per 4 ms tick and software clears
  each enabled counter after every round of its periodic work.
*/
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module ptm_timer (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic trigger_irq_line_i,
  input wire logic switch_irq_line_i,
  output logic ch1_overflow_irq_o,
  output logic ch2_overflow_irq_o,
  output logic ch3_overflow_irq_o,
  output logic sequence_end_irq_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] trg_sync;
    logic trg_prev;
    logic [1:0] sw_sync;
    logic sw_prev;
    logic pend;
    ptm_pkg::ptm_seq_t seq;
    logic [2:0][15:0] en;
    logic [2:0][15:0] cnt;
    logic [2:0][15:0] cmp;
    logic [2:0] ovf_done;
    logic [7:0] flag;
    logic [7:0] mask;
    logic [15:0] act_count;
    logic [31:0] rdata;
    logic slverr;
  } ptm_regs_t;

  // ----------------------------------------------------------------
  // reset value and channel map
  // ----------------------------------------------------------------
  localparam ptm_regs_t REGS_RESET = '{
    trg_sync: 2'h3,
    trg_prev: 1'b1,
    sw_sync: 2'h3,
    sw_prev: 1'b1,
    pend: 1'b0,
    seq: ptm_pkg::PTM_IDLE,
    en: {3{ptm_pkg::CHANNEL_OFF_VALUE}},
    cnt: {3{ptm_pkg::COUNTER_CLEAR_VALUE}},
    cmp: {3{ptm_pkg::CMP_RESET}},
    ovf_done: 3'h0,
    flag: ptm_pkg::FLAG_RESET,
    mask: ptm_pkg::MASK_RESET,
    act_count: 16'h0000,
    rdata: 32'h0000_0000,
    slverr: 1'b0
  };

  // channel to flag bit mapping
  // bit 3 stays with the trigger line, so channel 3 skips to bit 4
  localparam int unsigned CH_FLAG_BIT [3] = '{ptm_pkg::CH1_FLAG_BIT, ptm_pkg::CH2_FLAG_BIT,
                                              ptm_pkg::CH3_FLAG_BIT};

  // ----------------------------------------------------------------
  // state and reset copy
  // ----------------------------------------------------------------
  ptm_regs_t q;
  ptm_regs_t d;
  logic [1:0] rst_sync_q;
  logic rst_n;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // asserts at once, lifts on the clock so no flop sees reset end mid-cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic trg_fall;
  logic sw_fall;
  logic setup;
  logic wr_acc;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic hit;
  logic [11:0] ch_addr;

  always_comb begin
    d = q;
    flag_set = 8'h00;
    flag_clr = 8'h00;
    hit = 1'b0;
    ch_addr = 12'h000;

    // ----------------------------------------------------------------
    // pin inputs
    // ----------------------------------------------------------------
    // pin synchronisers; only the second stage feeds the edge detectors
    d.trg_sync = {q.trg_sync[0], trigger_irq_line_i};
    d.sw_sync = {q.sw_sync[0], switch_irq_line_i};
    d.trg_prev = q.trg_sync[1];
    d.sw_prev = q.sw_sync[1];
    trg_fall = q.trg_prev & ~q.trg_sync[1];
    sw_fall = q.sw_prev & ~q.sw_sync[1];
    if (sw_fall) begin
      flag_set[ptm_pkg::SWITCH_FLAG_BIT] = 1'b1;
    end

    // a trigger seen while busy is held, not dropped
    if (trg_fall) begin
      d.pend = 1'b1;
    end

    // ----------------------------------------------------------------
    // activation sequencer
    // ----------------------------------------------------------------
    case (q.seq)
      ptm_pkg::PTM_IDLE: begin
        if (q.pend) begin
          d.pend = trg_fall;
          d.seq = ptm_pkg::PTM_INC;
        end
      end
      ptm_pkg::PTM_INC: begin
        d.act_count = q.act_count + 16'h0001;
        for (int c = 0; c < ptm_pkg::NUM_CH; c++) begin
          // saturate so a neglected channel cannot wrap back below compare
          if (q.en[c] == ptm_pkg::CHANNEL_ON_VALUE && q.cnt[c] != ptm_pkg::COUNTER_MAX) begin
            d.cnt[c] = q.cnt[c] + 16'h0001;
          end
        end
        d.seq = ptm_pkg::PTM_CHECK;
      end
      ptm_pkg::PTM_CHECK: begin
        for (int c = 0; c < ptm_pkg::NUM_CH; c++) begin
          // one activation is one 4 ms tick, so compare counts ticks
          if (q.en[c] == ptm_pkg::CHANNEL_ON_VALUE && !q.ovf_done[c] &&
              q.cnt[c] >= q.cmp[c]) begin
            flag_set[CH_FLAG_BIT[c]] = 1'b1;
            d.ovf_done[c] = 1'b1;
          end
        end
        d.seq = ptm_pkg::PTM_IDLE;
      end
      default: begin
        d.seq = ptm_pkg::PTM_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // apb read decode and error, in setup
    // ----------------------------------------------------------------
    // latching read data in setup keeps prdata a flop output, one cycle behind a same-cycle event
    setup = psel_i & ~penable_i;
    wr_acc = psel_i & penable_i & pwrite_i;
    if (setup) begin
      d.rdata = 32'h0000_0000;
      if (paddr_i == ptm_pkg::IRQ_FLAG_ADDR) begin
        hit = 1'b1;
        d.rdata = {24'h000000, q.flag};
      end else if (paddr_i == ptm_pkg::IRQ_MASK_ADDR) begin
        hit = 1'b1;
        d.rdata = {24'h000000, q.mask};
      end else if (paddr_i == ptm_pkg::ACT_COUNT_ADDR) begin
        hit = 1'b1;
        d.rdata = {16'h0000, q.act_count};
      end else begin
        for (int c = 0; c < ptm_pkg::NUM_CH; c++) begin
          ch_addr = ptm_pkg::CH_BASE + 12'(c) * ptm_pkg::CH_STRIDE;
          if (paddr_i == ch_addr + ptm_pkg::EN_OFS) begin
            hit = 1'b1;
            d.rdata = {16'h0000, q.en[c]};
          end else if (paddr_i == ch_addr + ptm_pkg::CNT_OFS) begin
            hit = 1'b1;
            d.rdata = {16'h0000, q.cnt[c]};
          end else if (paddr_i == ch_addr + ptm_pkg::CMP_OFS) begin
            hit = 1'b1;
            d.rdata = {16'h0000, q.cmp[c]};
          end
        end
      end
      // the activation count is read only
      d.slverr = ~hit | (pwrite_i & paddr_i == ptm_pkg::ACT_COUNT_ADDR);
    end

    // ----------------------------------------------------------------
    // apb write, in access
    // ----------------------------------------------------------------
    // an errored setup blocks the write, so a refused address never lands
    if (wr_acc && !q.slverr) begin
      if (paddr_i == ptm_pkg::IRQ_FLAG_ADDR) begin
        if (pstrb_i[0]) begin
          flag_clr = pwdata_i[7:0];
        end
      end else if (paddr_i == ptm_pkg::IRQ_MASK_ADDR) begin
        if (pstrb_i[0]) begin
          d.mask = pwdata_i[7:0];
        end
      end else begin
        for (int c = 0; c < ptm_pkg::NUM_CH; c++) begin
          ch_addr = ptm_pkg::CH_BASE + 12'(c) * ptm_pkg::CH_STRIDE;
          if (paddr_i == ch_addr + ptm_pkg::EN_OFS) begin
            if (pstrb_i[0]) begin
              d.en[c][7:0] = pwdata_i[7:0];
            end
            if (pstrb_i[1]) begin
              d.en[c][15:8] = pwdata_i[15:8];
            end
          end else if (paddr_i == ch_addr + ptm_pkg::CNT_OFS) begin
            // host write beats a same-cycle increment and re-arms overflow
            if (pstrb_i[0]) begin
              d.cnt[c][7:0] = pwdata_i[7:0];
            end
            if (pstrb_i[1]) begin
              d.cnt[c][15:8] = pwdata_i[15:8];
            end
            d.ovf_done[c] = 1'b0;
          end else if (paddr_i == ch_addr + ptm_pkg::CMP_OFS) begin
            if (pstrb_i[0]) begin
              d.cmp[c][7:0] = pwdata_i[7:0];
            end
            if (pstrb_i[1]) begin
              d.cmp[c][15:8] = pwdata_i[15:8];
            end
          end
        end
      end
    end

    // ----------------------------------------------------------------
    // interrupt flags
    // ----------------------------------------------------------------
    // set beats clear; bit 3 belongs to the trigger and is never raised here
    d.flag = (q.flag & ~flag_clr) | flag_set;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= REGS_RESET;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata_o = q.rdata;
  // no wait states: every register answers in its first access cycle
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & q.slverr;
  assign ch1_overflow_irq_o = q.flag[ptm_pkg::CH1_FLAG_BIT];
  assign ch2_overflow_irq_o = q.flag[ptm_pkg::CH2_FLAG_BIT];
  assign ch3_overflow_irq_o = q.flag[ptm_pkg::CH3_FLAG_BIT];
  // the sequencer must keep running, so its end request stays quiet
  assign sequence_end_irq_o = 1'b0;
  // the per-channel lines ignore the mask; only the summary line is gated
  assign irq_o = |(q.flag & q.mask);

endmodule

`default_nettype wire

// file: ptm_timer_monitor.sv
/* checker for ptm_timer: apb error phase, irq flag stickiness, trigger to irq timing.
   assumes it is bound onto ptm_timer and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module ptm_timer_monitor (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pslverr_o,
  input wire logic trigger_irq_line_i,
  input wire logic ch1_overflow_irq_o,
  input wire logic ch2_overflow_irq_o,
  input wire logic ch3_overflow_irq_o,
  input wire logic sequence_end_irq_o,
  input wire logic irq_o
);
  logic wr;
  logic fw;
  logic trig_q;
  logic [4:0] since_q;
  assign wr = psel_i && penable_i && pwrite_i;
  assign fw = wr && paddr_i == ptm_pkg::IRQ_FLAG_ADDR && pstrb_i[0];
  // cycles since the trigger pin fell, saturating so idle time reads as long ago
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_q <= 1'b1;
      since_q <= 5'h1F;
    end else begin
      trig_q <= trigger_irq_line_i;
      since_q <= (trig_q && !trigger_irq_line_i) ? 5'h00 : since_q + {4'h0, since_q != 5'h1F};
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_no_seq_end; !sequence_end_irq_o; endproperty
  a_no_seq_end: assert property (p_no_seq_end)
    else $error("sequence end irq raised");
  property p_ch1_hold; ch1_overflow_irq_o && !(fw && pwdata_i[1]) |=> ch1_overflow_irq_o; endproperty
  a_ch1_hold: assert property (p_ch1_hold)
    else $error("channel 1 irq dropped without clear");
  property p_ch2_hold; ch2_overflow_irq_o && !(fw && pwdata_i[2]) |=> ch2_overflow_irq_o; endproperty
  a_ch2_hold: assert property (p_ch2_hold)
    else $error("channel 2 irq dropped without clear");
  property p_ch3_hold; ch3_overflow_irq_o && !(fw && pwdata_i[4]) |=> ch3_overflow_irq_o; endproperty
  a_ch3_hold: assert property (p_ch3_hold)
    else $error("channel 3 irq dropped without clear");
  property p_ch1_clear; fw && pwdata_i[1] && since_q > 5'h0F |=> !ch1_overflow_irq_o; endproperty
  a_ch1_clear: assert property (p_ch1_clear)
    else $error("channel 1 irq not cleared");
  property p_rise; $rose(ch1_overflow_irq_o) || $rose(ch2_overflow_irq_o) || $rose(ch3_overflow_irq_o)
    |-> since_q < 5'h10; endproperty
  a_rise: assert property (p_rise)
    else $error("channel irq rose with no trigger");
  property p_irq_hold; irq_o && !(wr && (paddr_i == ptm_pkg::IRQ_FLAG_ADDR ||
    paddr_i == ptm_pkg::IRQ_MASK_ADDR)) |=> irq_o; endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped without flag or mask write");
  property p_err_phase; pslverr_o |-> psel_i && penable_i; endproperty
  a_err_phase: assert property (p_err_phase)
    else $error("error outside access phase");
  c_ch1: cover property ($rose(ch1_overflow_irq_o));
  c_ch3: cover property ($rose(ch3_overflow_irq_o));
  c_irq: cover property ($rose(irq_o));
  c_err: cover property (pslverr_o);
endmodule
bind ptm_timer ptm_timer_monitor i_mon (.clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .pstrb_i, .pslverr_o, .trigger_irq_line_i, .ch1_overflow_irq_o, .ch2_overflow_irq_o,
  .ch3_overflow_irq_o, .sequence_end_irq_o, .irq_o);
`default_nettype wire

// file: ptm_trig_src.sv
/* host trigger pin model: one low pulse per request.
   assumes fire_i is a one-cycle request on clock_i. */
`timescale 1ns/1ps
`default_nettype none
module ptm_trig_src (
  input wire logic clock_i,
  input wire logic fire_i,
  output logic pin_o
);
  logic [1:0] low_q = 2'h0;
  // three low cycles: longer than the one low cycle the edge detector needs;
  // the 4 ms tick period is shortened to a few cycles to keep the run short
  always_ff @(posedge clock_i) begin
    if (fire_i) low_q <= 2'h3;
    else if (low_q != 2'h0) low_q <= low_q - 2'h1;
  end
  assign pin_o = (low_q == 2'h0); // idle high
endmodule
`default_nettype wire

// file: ptm_timer_test.sv
/* self-checking bench for ptm_timer: register table loop, then trigger scenarios.
   assumes ptm_trig_src as the trigger pin and an apb master in tasks. */
`timescale 1ns/1ps
`default_nettype none
module ptm_timer_test;
  typedef struct packed {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} ptm_row_t;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, sw = 1'b1, fire = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [3:0] pst = 4'h0;
  logic prdy, perr, e, trig, c1, c2, c3, se, irq;
  int err_total = 0, checked = 0;
  ptm_row_t rows [8];
  ptm_timer i_dut (.clock_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(pst), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .trigger_irq_line_i(trig), .switch_irq_line_i(sw), .ch1_overflow_irq_o(c1), .ch2_overflow_irq_o(c2),
    .ch3_overflow_irq_o(c3), .sequence_end_irq_o(se), .irq_o(irq));
  ptm_trig_src i_trig (.clock_i(clk), .fire_i(fire), .pin_o(trig));
  initial forever #10 clk = ~clk;
  task report_and_stop;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    pst <= 4'hF;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      report_and_stop;
    end
    rd = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, rd);
  endtask
  // one trigger pulse, then enough idle cycles for the activation to finish
  task fire_once;
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  initial begin
    rows = '{
      '{12'h000, 32'hABCD0001, 32'h00000001, 1'b0},
      '{12'h008, 32'h00000003, 32'h00000003, 1'b0},
      '{12'h018, 32'h00000001, 32'h00000001, 1'b0},
      '{12'h020, 32'h00000002, 32'h00000002, 1'b0},
      '{12'h00C, 32'h00000005, 32'h00000005, 1'b0},
      '{12'h028, 32'h00000012, 32'h00000012, 1'b0},
      '{12'h02C, 32'h00001234, 32'h00000000, 1'b1},
      '{12'h030, 32'h0000FFFF, 32'h00000000, 1'b1}};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("irq lines", 32'h0, {27'h0, c1, c2, c3, se, irq});
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      chk("write error", {31'h0, rows[i].e}, {31'h0, e});
      rdchk("read back", rows[i].a, rows[i].r);
    end
    fire_once;
    rdchk("ch1 count", 12'h004, 32'h1);
    rdchk("ch2 count", 12'h010, 32'h0);
    fire_once;
    chk("irqs ch3", 32'h3, {28'h0, c1, c2, c3, irq});
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h024, 32'h10);
    fire_once;
    fire_once;
    chk("irqs once", 32'h0, {28'h0, c1, c2, c3, irq});
    rdchk("ch1 after clear", 12'h004, 32'h2);
    fire_once;
    chk("irqs ch1", 32'h9, {28'h0, c1, c2, c3, irq});
    rdchk("flag ch1", 12'h024, 32'h2);
    apb(1'b1, 12'h024, 32'h2);
    sw <= 1'b0;
    repeat (3) @(posedge clk);
    sw <= 1'b1;
    repeat (8) @(posedge clk);
    rdchk("flag switch", 12'h024, 32'h1);
    chk("irq masked", 32'h0, {28'h0, c1, c2, c3, irq});
    apb(1'b1, 12'h00C, 32'h1);
    fire_once;
    chk("irqs ch2", 32'h4, {28'h0, c1, c2, c3, irq});
    apb(1'b1, 12'h024, 32'h17);
    rdchk("flag clear", 12'h024, 32'h0);
    // two triggers six cycles apart give two activations and no repeated overflow
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (4) @(posedge clk);
    fire_once;
    chk("irqs no repeat", 32'h0, {28'h0, c1, c2, c3, irq});
    rdchk("activations", 12'h02C, 32'h8);
    rdchk("ch2 count later", 12'h010, 32'h3);
    sw <= 1'b0;
    repeat (3) @(posedge clk);
    sw <= 1'b1;
    repeat (8) @(posedge clk);
    rdchk("flag switch again", 12'h024, 32'h1);
    // reset in mid-run clears flags, enables and the activation count
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("irq lines in reset", 32'h0, {27'h0, c1, c2, c3, se, irq});
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk("flag after reset", 12'h024, 32'h0);
    rdchk("enable after reset", 12'h000, 32'h0);
    rdchk("activations after reset", 12'h02C, 32'h0);
    report_and_stop;
  end
endmodule
`default_nettype wire
